// [pkg/pipe_if.sv]
// interface: one pipeline stage carrying an access from control to data side
interface pipe_if;
  import sram_port_pkg::*;
  logic valid;                 // access selected
  logic wr;                    // write access
  logic [ADDR_W-1:0] addr;     // effective address
  logic [LANES-1:0] lane_en_n; // byte mask, active low
  modport src (output valid, output wr, output addr, output lane_en_n);
  modport dst (input valid, input wr, input addr, input lane_en_n);
endinterface

// [pkg/sram_port_pkg.sv]
// package: widths, burst constants and latency for the synchronous memory port
package sram_port_pkg;
  localparam int ADDR_W = 16;          // address width
  localparam int LANE_W = 8;           // bits per byte lane
  localparam int LANES = 4;            // lanes a..d
  localparam int DATA_W = LANE_W * LANES;
  localparam int BURST_LEN = 4;        // wrap after fourth access
  localparam int RD_LATENCY = 2;       // edges from address to data
  localparam int WR_LATENCY = 2;       // edges from address to write data
  localparam logic [1:0] SEED_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  typedef enum logic [0:0] {CYC_READ, CYC_WRITE} cyc_t;
endpackage

// [verif/host_bus_model.sv]
// host side of the shared data lanes: resolves who drives the wire
module host_bus_model
  import sram_port_pkg::*;
(
  // clock
  input wire logic i_clk,
  // host write data
  input wire logic [DATA_W-1:0] i_host_dat,
  input wire logic i_host_drv,
  // device read side
  input wire logic [DATA_W-1:0] i_dev_dat,
  input wire logic [LANES-1:0] i_dev_oe,
  // resolved wire
  output logic [DATA_W-1:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] last_r; // last wire value, inverted when nobody drives
  // host drives write data only in its slot, never a held copy
  assign o_bus = i_host_drv ? i_host_dat : (|i_dev_oe) ? i_dev_dat : ~last_r;
  // remember the wire so a floating bus shows a changing pattern
  always_ff @(posedge i_clk) begin
    last_r <= o_bus;
  end
endmodule

// [verif/pipelined_sync_sram_port_tb.sv]
// bench for the pipelined synchronous memory port
module pipelined_sync_sram_port_tb;
  import sram_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, adv = 0, rw = 1, gate = 0, oe_n = 0, sleep = 0, bo = 0, hdrv = 0;
  logic [2:0] sel = 3'b001; // {primary, depth low, depth high}
  logic [2:0] cs = 3'b101; // selects applied to the port
  logic [ADDR_W-1:0] addr = '0;
  logic [LANES-1:0] mask = '1;
  logic [DATA_W-1:0] hdat = '0, din, dout, rd, v;
  logic [LANES-1:0] doe;
  int miscompares = 0, total_checks = 0;
  always #20 clk = ~clk;
  sync_sram_port dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr_in(addr), .i_chip_sel_n(cs[2]),
    .i_depth_select_n(cs[1]), .i_depth_select_hi(cs[0]), .i_advance_or_load(adv), .i_rd_wr_n(rw),
    .i_clk_gate_n(gate), .i_lane_wr_en_n(mask), .i_out_en_n(oe_n), .i_sleep_request(sleep),
    .i_burst_order_select(bo), .i_lane_io(din), .o_lane_io(dout), .o_lane_io_oe(doe));
  host_bus_model host (.i_clk(clk), .i_host_dat(hdat), .i_host_drv(hdrv), .i_dev_dat(dout),
    .i_dev_oe(doe), .o_bus(din));
  // compare and count
  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // inputs move a fixed 1 ns after the edge
  task step;
    @(posedge clk);
    #1;
  endtask
  // load cycle with mask in the address cycle
  task issue(input logic w, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m);
    adv = 0; cs = sel; rw = !w; addr = a; mask = m;
  endtask
  // deselected load keeps the pipe empty
  task idle;
    adv = 0; cs = 3'b101; rw = 1;
  endtask
  // write: data goes on the lanes for the second edge
  task wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
    issue(1, a, m); step; idle; step; hdat = d; hdrv = 1; step; hdrv = 0;
  endtask
  // read: data stands after the second edge
  task rdw(input logic [ADDR_W-1:0] a);
    issue(0, a, '1); step; idle; step; step; rd = dout;
  endtask
  task t_basic;
    wr(5, 4'h0, 32'hdeadbeef); rdw(5); chk(rd, 32'hdeadbeef);
    chk(32'(doe), 32'hf);
    oe_n = 1; #1; chk(32'(doe), 32'h0); oe_n = 0;
    $display("test basic done");
  endtask
  task t_mask;
    wr(5, 4'b1010, 32'h11223344); rdw(5); chk(rd, 32'hde22be44);
    $display("test mask done");
  endtask
  task t_desel;
    logic [2:0] bad [3] = '{3'b101, 3'b011, 3'b000};
    for (int i = 0; i < 3; i++) begin
      sel = bad[i]; wr(5, 4'h0, 32'h0); sel = 3'b001;
      rdw(5); chk(rd, 32'hde22be44);
    end
    $display("test deselect done");
  endtask
  task t_burst;
    for (int w = 8; w < 12; w++) wr(w, 4'h0, 32'h11110000 + w);
    for (int m = 0; m < 2; m++) begin
      bo = m[0]; issue(0, 9, '1); step;
      adv = 1; cs = 3'b010; rw = 0; step;
      for (int k = 0; k < 4; k++) begin
        step;
        chk(dout, 32'h11110008 + (m ? (1 ^ k) : ((1 + k) % 4)));
        if (k == 1) idle;
      end
    end
    $display("test burst done");
  endtask
  task t_gate_sleep;
    rdw(5); v = rd; issue(0, 8, '1); step; idle; gate = 1;
    repeat (3) step;
    chk(dout, v); gate = 0; step; step; chk(dout, 32'h11110008);
    sleep = 1; #1; chk(32'(doe), 32'h0);
    wr(5, 4'h0, 32'h0); sleep = 0; step; rdw(5); chk(rd, v);
    $display("test gate and sleep done");
  endtask
  task close_out;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence, reset held four cycles
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    step;
    t_basic; t_mask; t_desel; t_burst; t_gate_sleep;
    close_out;
  end
  // watchdog against a hang
  initial begin
    #400000;
    miscompares++;
    close_out;
  end
endmodule

// [verilog/burst_addr_gen.sv]
// burst counter: seeds from low address bits, steps linear or interleaved
module burst_addr_gen
  import sram_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_step,
  input wire logic i_load,
  input wire logic [1:0] i_seed,
  input wire logic i_interleave,
  // offset out
  output logic [1:0] o_offs
);
  logic [1:0] seed_r, seed_nxt;  // loaded low bits
  logic [1:0] cnt_r, cnt_nxt;    // access count in burst

  // next count: reload on load, wrap modulo four on advance
  always_comb begin
    seed_nxt = seed_r;
    cnt_nxt = cnt_r;
    if (i_load) begin
      seed_nxt = i_seed;
      cnt_nxt = 2'h0;
    end else if (i_step) begin
      cnt_nxt = cnt_r + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seed_r <= SEED_RST;
      cnt_r <= 2'h0;
    end else begin
      seed_r <= seed_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // interleaved xors the count in, linear adds it
  always_comb begin
    if (i_interleave) begin
      o_offs = seed_r ^ cnt_r;
    end else begin
      o_offs = seed_r + cnt_r;
    end
  end
endmodule

// [verilog/sync_sram_port.sv]
// top: pipelined synchronous memory with late write and burst counter
// Notes on behaviour
// - every enabled edge registers lane enables; address, selects, type on load only
// - low two address bits seed burst counter
// - write only lanes whose enable is low
// - mask travels with address to data
// - each enable governs its own lane
// - chip selects sampled on load cycles only
// - selected: primary low, depth low, depth high
// - output drive only while output enable low
// - advance high steps the burst counter
// - advance ignores read/write select
// - advance low loads a new address
// - clock gate high freezes all state
// - sleep keeps array contents intact
// - sleep ignores every other input except reset
// - low select writes, high reads, load only
// - write data taken two edges after address
// - burst order pin: low linear, high interleaved
// - burst wraps after fourth access
module sync_sram_port
  import sram_port_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DEPTH = 64
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // address and control
  input wire logic [AW-1:0] i_addr_in,
  input wire logic i_chip_sel_n,
  input wire logic i_depth_select_n,
  input wire logic i_depth_select_hi,
  input wire logic i_advance_or_load,
  input wire logic i_rd_wr_n,
  input wire logic i_clk_gate_n,
  input wire logic [LANES-1:0] i_lane_wr_en_n,
  // asynchronous pins
  input wire logic i_out_en_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order_select,
  // data lanes a..d, split in/out/enable
  input wire logic [DATA_W-1:0] i_lane_io,
  output logic [DATA_W-1:0] o_lane_io,
  output logic [LANES-1:0] o_lane_io_oe
);
  localparam int IW = $clog2(DEPTH);

  pipe_if st1();  // access after address edge
  pipe_if st2();  // access at data edge

  logic [DATA_W-1:0] mem_r [DEPTH];  // array, flip-flops
  logic [DATA_W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] base_r, base_nxt;   // loaded base address
  logic wr_r, wr_nxt;                // burst cycle type
  logic sel_r, sel_nxt;              // burst selected
  logic [LANES-1:0] mask_r, mask_nxt;
  logic [1:0] offs;                  // burst offset
  logic run_w;                       // edge is honoured
  logic load;                        // load cycle
  logic [AW-1:0] acc_addr;           // address of current access
  logic s1_valid_r, s1_wr_r, s2_valid_r, s2_wr_r;
  logic [AW-1:0] s1_addr_r, s2_addr_r;
  logic [LANES-1:0] s1_mask_r, s2_mask_r;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic rd_vld_r, rd_vld_nxt;        // registered read present
  logic [LANES-1:0] oe_r;

  // sleep overrides gate, so nothing moves and array is kept
  assign run_w = !i_clk_gate_n && !i_sleep_request;
  assign load = !i_advance_or_load;

  burst_addr_gen u_burst (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_step(run_w && !load),
    .i_load(run_w && load),
    .i_seed(i_addr_in[1:0]),
    .i_interleave(i_burst_order_select),
    .o_offs(offs)
  );

  // access control: load takes selects and type, advance keeps them
  always_comb begin
    base_nxt = base_r;
    wr_nxt = wr_r;
    sel_nxt = sel_r;
    mask_nxt = mask_r;
    if (run_w) begin
      mask_nxt = i_lane_wr_en_n;
      if (load) begin
        base_nxt = i_addr_in;
        // selects looked at here only
        sel_nxt = !i_chip_sel_n && !i_depth_select_n && i_depth_select_hi;
        wr_nxt = !i_rd_wr_n;
      end
      // advance: select line ignored, type held
    end
  end

  // current access address: base with burst offset in the low bits
  assign acc_addr = {base_r[AW-1:2], offs};

  assign st1.valid = s1_valid_r;
  assign st1.wr = s1_wr_r;
  assign st1.addr = s1_addr_r;
  assign st1.lane_en_n = s1_mask_r;
  assign st2.valid = s2_valid_r;
  assign st2.wr = s2_wr_r;
  assign st2.addr = s2_addr_r;
  assign st2.lane_en_n = s2_mask_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base_r <= AW'(ADDR_RST);
      wr_r <= 1'b0;
      sel_r <= 1'b0;
      mask_r <= '1;
      s1_valid_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_addr_r <= AW'(ADDR_RST);
      s1_mask_r <= '1;
      s2_valid_r <= 1'b0;
      s2_wr_r <= 1'b0;
      s2_addr_r <= AW'(ADDR_RST);
      s2_mask_r <= '1;
    end else begin
      base_r <= base_nxt;
      wr_r <= wr_nxt;
      sel_r <= sel_nxt;
      mask_r <= mask_nxt;
      if (run_w) begin
        // stage 1 sees this edge's access; stage 2 the previous one
        s1_valid_r <= sel_nxt;
        s1_wr_r <= wr_nxt;
        s1_addr_r <= load ? i_addr_in : {acc_addr[AW-1:2], offs_next()};
        s1_mask_r <= mask_nxt;
        s2_valid_r <= s1_valid_r;
        s2_wr_r <= s1_wr_r;
        s2_addr_r <= s1_addr_r;
        s2_mask_r <= s1_mask_r;
      end
    end
  end

  // address the advance is about to produce, matching burst counter
  function automatic logic [1:0] offs_next();
    logic [1:0] seed;
    logic [1:0] cnt;
    // base low bits equal the counter seed; recover the count from the offset
    seed = base_r[1:0];
    cnt = i_burst_order_select ? (offs ^ seed) : (offs - seed);
    return i_burst_order_select ? (seed ^ (cnt + 2'h1)) : (offs + 2'h1);
  endfunction

  // array: late write at second edge after address, per-lane mask
  generate
    for (genvar w = 0; w < DEPTH; w++) begin : g_word
      for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_comb begin
          mem_nxt[w][l*LANE_W +: LANE_W] = mem_r[w][l*LANE_W +: LANE_W];
          // stage 2 holds the access loaded two honoured edges ago
          if (run_w && st2.valid && st2.wr && !st2.lane_en_n[l]
              && st2.addr[IW-1:0] == IW'(w)) begin
            mem_nxt[w][l*LANE_W +: LANE_W] = i_lane_io[l*LANE_W +: LANE_W];
          end
        end
      end
      // no reset on the array; sleep blocks writes so contents stay
      always_ff @(posedge i_clk) begin
        mem_r[w] <= mem_nxt[w];
      end
    end
  endgenerate

  // read data registered at second edge after the address
  always_comb begin
    dout_nxt = dout_r;
    rd_vld_nxt = rd_vld_r;
    if (run_w) begin
      rd_vld_nxt = st2.valid && !st2.wr;
      if (st2.valid && !st2.wr) begin
        dout_nxt = mem_r[st2.addr[IW-1:0]];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_r <= '0;
      rd_vld_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      rd_vld_r <= rd_vld_nxt;
    end
  end

  // output enable follows the async pin without waiting for a clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_r <= '0;
    end else begin
      oe_r <= {LANES{rd_vld_nxt}};
    end
  end

  assign o_lane_io = dout_r;
  assign o_lane_io_oe = (i_out_en_n || i_sleep_request) ? '0 : oe_r;

  // checks
  a_sel_on_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_w && load) |=> sel_r == $past(!i_chip_sel_n && !i_depth_select_n && i_depth_select_hi))
    else $error("select not taken on load");
  a_sel_kept_adv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_w && !load) |=> $stable(sel_r) && $stable(wr_r))
    else $error("select or type changed on advance");
  a_gate_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !run_w |=> $stable(base_r) && $stable(s1_addr_r) && $stable(dout_r))
    else $error("state moved while gated");
  a_oe_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_out_en_n |-> o_lane_io_oe == '0)
    else $error("drive while output enable high");
  a_load_base: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_w && load) |=> base_r == $past(i_addr_in))
    else $error("address not loaded");
  a_type_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_w && load) |=> wr_r == $past(!i_rd_wr_n))
    else $error("cycle type wrong");
  a_mask_pipe: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_w ##1 run_w) |=> st2.lane_en_n == $past(i_lane_wr_en_n, 2))
    else $error("mask lost");
  a_read_lat: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_w && st2.valid && !st2.wr) |=> rd_vld_r)
    else $error("read data late");
  a_sleep_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_sleep_request |=> $stable(base_r) && $stable(sel_r))
    else $error("state moved in sleep");
  // selected write load, then one more honoured edge moves it to stage 2
  sequence s_wr_load;
    run_w && load && !i_rd_wr_n && !i_chip_sel_n && !i_depth_select_n && i_depth_select_hi;
  endsequence
  a_wr_at_data: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_wr_load ##1 run_w |=> st2.valid && st2.wr && st2.addr == $past(i_addr_in, 2))
    else $error("write not at data edge");
endmodule
